// >>> mmd_consts.svh
// constants of the memory map decoder: offsets, bounds, reset values, timing
// assumes a 20-bit byte address from the core and a 125 MHz system clock
// ****************************************************************
// Behaviour
// [R1] decode a 1 Mbyte space for core fetches and data accesses
// [R2] placement instruction runs once after reset; only first one counts
// [R3] low placement: data area 0F700H/0FB00H up to 0FFFFH per rom variant
// [R4] low placement: rom 0-0F5FFH or 0-07FFFH; rom from 0F600H unreachable
// [R5] high placement: data area FF700H/FFB00H up to FFFFFH per variant
// [R6] high placement: rom 0-0FFFFH or 0-07FFFH
// [R7] unclaimed addresses go external only in extension mode
// [R8] on rom and data overlap the data area wins
// [R9] fast fetch: 2 bytes per 2 clocks from rom, else external speed
// [R10] waits inserted on rom fetch only at external-equivalent timing
// [R11] reset clears fast fetch selection
// [R12] core must not fetch from fast ram or register area
// [R13] 00000H-0003FH reserved as vector table
// [R14] fixed vector slots: reset, nmi, operand error, break, peripherals
// [R15] context-switch vectors hold a register bank number
// [R16] vectors are 16 bits, so vector branches stay in base area
// [R17] table call reads target from 00040H-0007FH, 32 entries
// [R18] fixed-area call targets 00800H-00FFFH
// [R19] base area 0-FFFFH serves entries, table calls, 16-bit modes
// [R20] unused vector slots decode as ordinary memory
// [R21] extension mode chosen by four-bit field of extension mode register
// [R22] placement held in write-once flag; low assumed until written
// ****************************************************************
`ifndef MMD_CONSTS_SVH
`define MMD_CONSTS_SVH
`define MMD_ROM_END_64K 20'h0ffff
`define MMD_ROM_END_32K 20'h07fff
`define MMD_ROM_LOW_END_64K 20'h0f5ff
`define MMD_DATA_LOW_64K 20'h0f700
`define MMD_DATA_LOW_32K 20'h0fb00
`define MMD_HIGH_OFFSET 20'hf0000
`define MMD_BASE_END 20'h0ffff
`define MMD_FRAM_LO 16'hfd00
`define MMD_FRAM_HI 16'hfeff
`define MMD_SFR_LO 16'hff00
`define MMD_VEC_END 20'h0003f
`define MMD_VEC_RESET 20'h00000
`define MMD_VEC_NMI 20'h00002
`define MMD_VEC_PERIPH_END 20'h00036
`define MMD_VEC_OPERR 20'h0003c
`define MMD_VEC_BREAK 20'h0003e
`define MMD_TABLE_CALL_INSTRUCTION_LO 20'h00040
`define MMD_TABLE_CALL_INSTRUCTION_HI 20'h0007f
`define MMD_FIXED_AREA_CALL_INSTRUCTION_LO 20'h00800
`define MMD_FIXED_AREA_CALL_INSTRUCTION_HI 20'h00fff
`define MMD_EXT_OFF 4'h0
`define MMD_FAST_FETCH_RST 1'b0
`define MMD_FAST_FETCH_CYC 2
`endif

// >>> mmd_pkg.sv
// types of the memory map decoder
// assumes mmd_consts.svh is compiled alongside
package mmd_pkg;
    typedef enum logic [1:0] {
        MMD_TGT_NONE = 2'b00,
        MMD_TGT_ROM = 2'b01,
        MMD_TGT_DATA = 2'b10,
        MMD_TGT_EXT = 2'b11
    } mmd_target_t;

    typedef enum logic [2:0] {
        MMD_VEC_NONE = 3'b000,
        MMD_VEC_RST = 3'b001,
        MMD_VEC_NMI_C = 3'b010,
        MMD_VEC_PERIPH = 3'b011,
        MMD_VEC_OPERR_C = 3'b100,
        MMD_VEC_BRK = 3'b101
    } mmd_vec_t;

    typedef struct packed {
        logic valid;
        logic fetch;
        logic [19:0] addr;
    } mmd_req_t;

    typedef struct packed {
        mmd_target_t target;
        logic data_fram;
        logic data_sfr;
        logic fetch_fault;
        logic [1:0] wait_cycles;
        logic fast_fetch;
    } mmd_dec_t;

    typedef struct packed {
        logic base;
        logic vec_table;
        mmd_vec_t vec_cause;
        logic table_call_instruction_table;
        logic [4:0] table_call_instruction_index;
        logic fixed_area_call_instruction_area;
    } mmd_region_t;
endpackage : mmd_pkg

// >>> mmd_decoder.sv
// memory map decoder: maps core requests onto rom, data area or external memory
// assumes the core holds req_i stable for one cycle; results are registered
`timescale 1ns/1ps
`include "mmd_consts.svh"
module mmd_decoder
    import mmd_pkg::*;
#(
    parameter bit ROM_64K = 1'b1,
    parameter int EXT_WAITS = 1
) (
    input wire logic clk_i,
    input wire logic arst_n_i,
    input wire mmd_req_t req_i,
    input wire logic place_wr_i,
    input wire logic place_high_i,
    input wire logic [3:0] extension_mode_field_i,
    input wire logic fast_internal_fetch_bit_i,
    input wire logic mode_wr_i,
    output logic placement_high_o,
    output logic placement_locked_o,
    output logic fast_fetch_o,
    output logic ext_mode_o,
    output logic dec_valid_o,
    output mmd_dec_t dec_o,
    output mmd_region_t region_o
);
    // ****************************************************************
    // placement and mode state
    // ****************************************************************
    logic locked;
    logic high;
    logic fast;
    logic [3:0] ext_field;

    // only the first placement write counts, until the next reset
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            locked <= 1'b0; // [R22]
            high <= 1'b0;
        end else if (place_wr_i && !locked) begin // [R2]
            locked <= 1'b1;
            high <= place_high_i; // [R22]
        end
    end

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            fast <= `MMD_FAST_FETCH_RST; // [R11]
            ext_field <= `MMD_EXT_OFF;
        end else if (mode_wr_i) begin
            fast <= fast_internal_fetch_bit_i; // [R9]
            ext_field <= extension_mode_field_i; // [R21]
        end
    end

    assign placement_high_o = high;
    assign placement_locked_o = locked;
    assign fast_fetch_o = fast;
    assign ext_mode_o = (ext_field != `MMD_EXT_OFF); // [R21]

    // ****************************************************************
    // address decode
    // ****************************************************************
    logic [19:0] a;
    logic [19:0] data_lo;
    logic [19:0] rom_end;
    logic in_data;
    logic in_rom;
    logic [15:0] low16;
    mmd_dec_t next_dec;
    mmd_region_t next_reg;

    assign a = req_i.addr; // [R1]
    assign low16 = a[15:0];

    always_comb begin
        data_lo = ROM_64K ? `MMD_DATA_LOW_64K : `MMD_DATA_LOW_32K; // [R3]
        if (high) begin
            data_lo = data_lo + `MMD_HIGH_OFFSET; // [R5]
        end
        if (ROM_64K) begin
            rom_end = high ? `MMD_ROM_END_64K : `MMD_ROM_LOW_END_64K; // [R4] [R6]
        end else begin
            rom_end = `MMD_ROM_END_32K; // [R4] [R6]
        end
        // data area runs to the top of its page in both placements
        in_data = (a >= data_lo) && (a[15:0] >= data_lo[15:0])
                  && (a[19:16] == data_lo[19:16]);
        in_rom = (a <= rom_end);
    end

    always_comb begin
        next_dec = '0;
        next_dec.fast_fetch = fast;
        if (in_data) begin
            // data area shadows any rom behind it
            next_dec.target = MMD_TGT_DATA; // [R8]
            next_dec.data_fram = (low16 >= `MMD_FRAM_LO) && (low16 <= `MMD_FRAM_HI);
            next_dec.data_sfr = (low16 >= `MMD_SFR_LO);
            // flag only; the core is expected never to do this
            next_dec.fetch_fault = req_i.fetch
                && (next_dec.data_fram || next_dec.data_sfr); // [R12]
        end else if (in_rom) begin
            next_dec.target = MMD_TGT_ROM;
            if (req_i.fetch && !fast) begin
                next_dec.wait_cycles = 2'(EXT_WAITS); // [R10]
            end
        end else if (ext_mode_o) begin
            next_dec.target = MMD_TGT_EXT; // [R7]
            next_dec.wait_cycles = 2'(EXT_WAITS);
        end else begin
            next_dec.target = MMD_TGT_NONE; // [R7]
        end
    end

    // ****************************************************************
    // base area regions
    // ****************************************************************
    always_comb begin
        next_reg = '0;
        next_reg.base = (a <= `MMD_BASE_END); // [R19] [R16]
        next_reg.vec_table = (a <= `MMD_VEC_END); // [R13]
        next_reg.vec_cause = MMD_VEC_NONE; // [R20]
        if (a[0] == 1'b0) begin
            if (a == `MMD_VEC_RESET) begin
                next_reg.vec_cause = MMD_VEC_RST; // [R14]
            end else if (a == `MMD_VEC_NMI) begin
                next_reg.vec_cause = MMD_VEC_NMI_C; // [R14]
            end else if (a <= `MMD_VEC_PERIPH_END) begin
                // slot holds an address or a bank number, opaque here
                next_reg.vec_cause = MMD_VEC_PERIPH; // [R14] [R15]
            end else if (a == `MMD_VEC_OPERR) begin
                next_reg.vec_cause = MMD_VEC_OPERR_C; // [R14]
            end else if (a == `MMD_VEC_BREAK) begin
                next_reg.vec_cause = MMD_VEC_BRK; // [R14]
            end
        end
        next_reg.table_call_instruction_table = (a >= `MMD_TABLE_CALL_INSTRUCTION_LO) && (a <= `MMD_TABLE_CALL_INSTRUCTION_HI); // [R17]
        next_reg.table_call_instruction_index = next_reg.table_call_instruction_table ? a[5:1] : 5'h00; // [R17]
        next_reg.fixed_area_call_instruction_area = (a >= `MMD_FIXED_AREA_CALL_INSTRUCTION_LO) && (a <= `MMD_FIXED_AREA_CALL_INSTRUCTION_HI); // [R18]
    end

    // ****************************************************************
    // registered results
    // ****************************************************************
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            dec_valid_o <= 1'b0;
            dec_o <= '0;
            region_o <= '0;
        end else begin
            dec_valid_o <= req_i.valid;
            if (req_i.valid) begin
                dec_o <= next_dec;
                region_o <= next_reg;
            end
        end
    end
endmodule : mmd_decoder

// >>> mmd_core_model.sv
// core model: one request per go pulse, registered
// assumes go_i is driven just after the rising edge
`timescale 1ns/1ps
module mmd_core_model
    import mmd_pkg::*;
(
    input wire logic clk_i,
    input wire logic arst_n_i,
    input wire logic go_i,
    input wire logic fetch_i,
    input wire logic [19:0] addr_i,
    output mmd_req_t req_o
);
    // idle address toggles so a stale value never passes
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            req_o <= '0;
        end else begin
            req_o.valid <= go_i;
            req_o.fetch <= fetch_i && (addr_i[15:0] < 16'hfd00);
            req_o.addr <= go_i ? addr_i : ~req_o.addr;
        end
    end
endmodule : mmd_core_model

// >>> mmd_decoder_chk.sv
// checker on the decoder ports
// assumes bind onto mmd_decoder, one clock domain
`timescale 1ns/1ps
module mmd_decoder_chk
    import mmd_pkg::*;
#(parameter bit ROM_64K = 1'b1) (
    input wire logic clk_i,
    input wire logic arst_n_i,
    input wire mmd_req_t req_i,
    input wire logic place_wr_i,
    input wire logic place_high_i,
    input wire logic [3:0] extension_mode_field_i,
    input wire logic fast_internal_fetch_bit_i,
    input wire logic mode_wr_i,
    input wire logic placement_high_o,
    input wire logic placement_locked_o,
    input wire logic fast_fetch_o,
    input wire logic ext_mode_o,
    input wire logic dec_valid_o,
    input wire mmd_dec_t dec_o
);
    localparam logic [19:0] DLO = ROM_64K ? 20'h0f700 : 20'h0fb00;
    default clocking @(posedge clk_i); endclocking
    default disable iff (!arst_n_i);
    a_answer_next: assert property (req_i.valid |=> dec_valid_o)
        else $error("late answer");
    a_lock_holds: assert property (placement_locked_o |=>
        placement_locked_o && $stable(placement_high_o)) else $error("lock lost");
    a_place_take: assert property (place_wr_i && !placement_locked_o |=>
        placement_locked_o && placement_high_o == $past(place_high_i)) else $error("place");
    a_mode_take: assert property (mode_wr_i |=> fast_fetch_o ==
        $past(fast_internal_fetch_bit_i) && ext_mode_o == ($past(extension_mode_field_i) != 4'h0))
        else $error("mode");
    a_low_data: assert property (req_i.valid && !placement_high_o && req_i.addr >= DLO
        && req_i.addr <= 20'h0ffff |=> dec_o.target == MMD_TGT_DATA) else $error("low data");
    a_high_data: assert property (req_i.valid && placement_high_o
        && req_i.addr >= (DLO | 20'hf0000) |=> dec_o.target == MMD_TGT_DATA) else $error("hi data");
    a_fast_nowait: assert property (req_i.valid && req_i.fetch && fast_fetch_o
        && req_i.addr <= 20'h07fff |=> dec_o.wait_cycles == 2'h0) else $error("wait");
    a_ext_gated: assert property (req_i.valid && !ext_mode_o |=>
        dec_o.target != MMD_TGT_EXT) else $error("ext");
endmodule : mmd_decoder_chk
bind mmd_decoder mmd_decoder_chk #(.ROM_64K(ROM_64K)) u_mmd_decoder_chk (.clk_i, .arst_n_i,
    .req_i, .place_wr_i, .place_high_i, .extension_mode_field_i, .fast_internal_fetch_bit_i,
    .mode_wr_i, .placement_high_o, .placement_locked_o, .fast_fetch_o, .ext_mode_o,
    .dec_valid_o, .dec_o);

// >>> mmd_decoder_tb.sv
// bench for the decoder, 64K variant, one wait at external speed
// assumes core model and checker compiled first
`timescale 1ns/1ps
module mmd_decoder_tb;
    import mmd_pkg::*;
    logic clk_i = 1'b0, arst_n_i = 1'b0, go = 1'b0, fe = 1'b0;
    logic pw = 1'b0, ph = 1'b0, mw = 1'b0, ff = 1'b0, p_hi, p_lk, fast, ext, dv;
    logic [3:0] mf = 4'h0;
    logic [19:0] addr = 20'h0;
    mmd_req_t req;
    mmd_dec_t dec;
    mmd_region_t rg;
    int n_errors = 0, cmp_count = 0;
    always #4 clk_i = ~clk_i;
    mmd_core_model u_mmd_core_model (.clk_i, .arst_n_i, .go_i(go), .fetch_i(fe),
        .addr_i(addr), .req_o(req));
    mmd_decoder u_mmd_decoder (.clk_i, .arst_n_i, .req_i(req), .place_wr_i(pw),
        .place_high_i(ph), .extension_mode_field_i(mf), .fast_internal_fetch_bit_i(ff),
        .mode_wr_i(mw), .placement_high_o(p_hi), .placement_locked_o(p_lk),
        .fast_fetch_o(fast), .ext_mode_o(ext), .dec_valid_o(dv), .dec_o(dec), .region_o(rg));
    task automatic finish_test;
        if (n_errors == 0 && cmp_count > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : finish_test
    task automatic chk(input string nm, input logic [19:0] e, input logic [19:0] g);
        cmp_count++;
        if (g !== e) begin
            n_errors++;
            $display("[FAIL] %s exp %h got %h", nm, e, g);
        end
    endtask : chk
    task automatic access(input logic [19:0] a, input logic f);
        @(posedge clk_i);
        go <= 1'b1;
        addr <= a;
        fe <= f;
        @(posedge clk_i);
        go <= 1'b0;
        for (int i = 0; i < 4 && dv !== 1'b1; i++) @(negedge clk_i);
        if (dv !== 1'b1) begin
            n_errors++;
            finish_test();
        end
    endtask : access
    task automatic set_mode(input logic [3:0] m, input logic f);
        @(posedge clk_i);
        mw <= 1'b1;
        mf <= m;
        ff <= f;
        @(posedge clk_i);
        mw <= 1'b0;
    endtask : set_mode
    task automatic place(input logic h);
        @(posedge clk_i);
        pw <= 1'b1;
        ph <= h;
        @(posedge clk_i);
        pw <= 1'b0;
        @(negedge clk_i);
    endtask : place
    task automatic t_low;
        logic [19:0] a[5] = '{20'h0, 20'h0f5ff, 20'h0f600, 20'h0f700, 20'h10000};
        logic [1:0] t[5] = '{2'h1, 2'h1, 2'h0, 2'h2, 2'h0};
        @(negedge clk_i);
        chk("reset", 20'h0, {p_hi, p_lk, fast, ext});
        for (int i = 0; i < 5; i++) begin
            access(a[i], 1'b0);
            chk("target", t[i], dec.target);
        end
        chk("base", 20'h0, rg.base);
        access(20'h0, 1'b1);
        chk("slow", 20'h1, {dec.fast_fetch, dec.wait_cycles});
        access(20'h0f700, 1'b1);
        chk("pram", 20'h10, {dec.target, dec.data_fram, dec.data_sfr, dec.fetch_fault});
        access(20'h0fd00, 1'b0);
        chk("fram", 20'h14, {dec.target, dec.data_fram, dec.data_sfr, dec.fetch_fault});
        access(20'h0ff00, 1'b0);
        chk("sfr", 20'h12, {dec.target, dec.data_fram, dec.data_sfr, dec.fetch_fault});
        set_mode(4'h1, 1'b1);
        access(20'h10000, 1'b0);
        chk("ext", 20'h3, dec.target);
        access(20'h0, 1'b1);
        chk("fast", 20'h4, {dec.fast_fetch, dec.wait_cycles});
    endtask : t_low
    task automatic t_region;
        logic [19:0] a[7] = '{20'h0, 20'h2, 20'h4, 20'h36, 20'h3c, 20'h3e, 20'h38};
        logic [2:0] c[7] = '{3'h1, 3'h2, 3'h3, 3'h3, 3'h4, 3'h5, 3'h0};
        for (int i = 0; i < 7; i++) begin
            access(a[i], 1'b0);
            chk("vector", {1'b1, c[i]}, {rg.vec_table, rg.vec_cause});
        end
        access(20'h1, 1'b0);
        chk("vector", 20'h8, {rg.vec_table, rg.vec_cause});
        access(20'h7e, 1'b0);
        chk("table", 20'h3f, {rg.table_call_instruction_table, rg.table_call_instruction_index});
        access(20'h800, 1'b0);
        chk("fixed_area_call_instruction", 20'h3, {rg.base, rg.fixed_area_call_instruction_area});
        access(20'h7ff, 1'b0);
        chk("fixed_area_call_instruction", 20'h0, rg.fixed_area_call_instruction_area);
    endtask : t_region
    task automatic t_place;
        place(1'b1);
        chk("placed", 20'h3, {p_hi, p_lk});
        place(1'b0);
        chk("locked", 20'h3, {p_hi, p_lk});
        access(20'h0f700, 1'b0);
        chk("rom", 20'h1, dec.target);
        access(20'hff700, 1'b0);
        chk("data", 20'h2, dec.target);
        arst_n_i <= 1'b0;
        @(posedge clk_i);
        arst_n_i <= 1'b1;
        @(negedge clk_i);
        chk("rst", 20'h0, {p_hi, p_lk, fast, ext});
    endtask : t_place
    initial begin
        repeat (6) @(posedge clk_i);
        arst_n_i <= 1'b1;
        t_low();
        t_region();
        t_place();
        finish_test();
    end
endmodule : mmd_decoder_tb
